// ### logic/debug_status_control.v
`include "debug_status_control_defines.vh"
`default_nettype none

// ****************************************************************
// debug status and control register with halt sequencing
// ****************************************************************
module debug_status_control
#(
    parameter ADDR_WIDTH = `CPU_ADDR_WIDTH
)
(
    // clock and reset
    input  wire                  clk_sys,
    input  wire                  rstn,
    // target reset taken by the system
    input  wire                  target_reset,
    // serial command decoder side
    input  wire                  cmd_read_status,
    input  wire                  cmd_write_control,
    input  wire [7:0]            cmd_wdata,
    input  wire                  cmd_background,
    input  wire                  cmd_go,
    input  wire                  mem_cmd_start,
    input  wire                  mem_fail_wait_stop,
    input  wire                  mem_fail_slow,
    output reg  [7:0]            status_rdata,
    output reg                   status_rvalid,
    output reg                   background_refused,
    output wire                  active_cmds_allowed,
    // cpu side
    input  wire [ADDR_WIDTH-1:0] cpu_addr,
    input  wire                  cpu_addr_valid,
    input  wire                  opcode_fetch,
    input  wire                  instr_boundary,
    input  wire                  tagged_at_queue_end,
    input  wire                  cpu_wait_stop,
    input  wire [ADDR_WIDTH-1:0] breakpoint_match_address,
    output wire                  tag_opcode,
    output wire                  halt_active_flag,
    output reg                   cpu_wake_req,
    output reg                   swi_req,
    // link clock choice
    output wire                  link_clock_select
);

    // ****************************************************************
    // halt sequencer states
    // ****************************************************************
    localparam [2:0] ST_RUN  = 3'b001;
    localparam [2:0] ST_HALT = 3'b010;
    localparam [2:0] ST_WAIT = 3'b100;

    // ****************************************************************
    // storage
    // ****************************************************************
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg       permit_reg;
    reg       bp_enable_reg;
    reg       force_tag_reg;
    reg       clk_select_reg;
    reg       ws_entry_reg;
    reg       ws_entry_next;
    reg       ws_fail_reg;
    reg       slow_fail_reg;
    reg       force_pend_reg;
    reg       force_pend_next;
    reg       halt_request;
    reg       swi_next;
    reg       wake_next;
    reg       refuse_next;

    wire       bp_hit;
    wire       halted;
    wire       in_wait;
    wire       ws_status;
    wire [7:0] scr_value;

    // ****************************************************************
    // breakpoint comparator
    // ****************************************************************
    breakpoint_compare
    #(
        .ADDR_WIDTH     (ADDR_WIDTH)
    )
    u_compare
    (
        .compare_enable (bp_enable_reg),
        .bus_valid      (cpu_addr_valid),
        .bus_addr       (cpu_addr),
        .match_addr     (breakpoint_match_address),
        .addr_hit       (bp_hit)
    );

    // ****************************************************************
    // status view
    // ****************************************************************
    // decoded state bits
    assign halted    = state_reg[1];
    assign in_wait   = state_reg[2];

    // live wait/stop or a halt that was entered out of wait/stop
    assign ws_status = cpu_wait_stop | in_wait | ws_entry_reg;

    // assembled register image, active flag comes from the sequencer
    assign scr_value = {permit_reg,
                        halted,
                        bp_enable_reg,
                        force_tag_reg,
                        clk_select_reg,
                        ws_status,
                        ws_fail_reg,
                        slow_fail_reg};

    assign halt_active_flag    = halted;
    assign link_clock_select   = clk_select_reg;

    // active-mode commands need the halt and a cpu that is awake
    assign active_cmds_allowed = halted & ~cpu_wait_stop;

    // tag form marks the fetched opcode; force form never tags
    assign tag_opcode = bp_hit & ~force_tag_reg & opcode_fetch;

    // ****************************************************************
    // force breakpoint pending
    // ****************************************************************
    // a force match may land mid-instruction, so hold it to the boundary
    always @*
    begin
        force_pend_next = force_pend_reg;
        if (!bp_enable_reg || !state_reg[0])
        begin
            force_pend_next = 1'b0;
        end
        else if (instr_boundary)
        begin
            force_pend_next = 1'b0;
        end
        else if (bp_hit && force_tag_reg)
        begin
            force_pend_next = 1'b1;
        end
    end

    // ****************************************************************
    // halt sequencer
    // ****************************************************************
    // request from breakpoints while the application runs
    always @*
    begin
        halt_request = 1'b0;
        if (state_reg[0] && bp_enable_reg)
        begin
            if (force_tag_reg)
            begin
                halt_request = instr_boundary & (force_pend_reg | bp_hit);
            end
            else
            begin
                halt_request = tagged_at_queue_end;
            end
        end
    end

    // next state, software interrupt fallback and refusals
    always @*
    begin
        state_next    = state_reg;
        ws_entry_next = ws_entry_reg;
        swi_next      = 1'b0;
        wake_next     = 1'b0;
        refuse_next   = 1'b0;
        case (state_reg)
            ST_RUN:
            begin
                if (cmd_background)
                begin
                    if (permit_reg)
                    begin
                        state_next = ST_HALT;
                    end
                    else
                    begin
                        refuse_next = 1'b1;
                    end
                end
                else if (halt_request)
                begin
                    // without permit the breakpoint becomes a software interrupt
                    if (permit_reg)
                    begin
                        state_next = ST_HALT;
                    end
                    else
                    begin
                        swi_next = 1'b1;
                    end
                end
                else if (cpu_wait_stop)
                begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (cmd_background)
                begin
                    if (permit_reg)
                    begin
                        state_next    = ST_HALT;
                        ws_entry_next = 1'b1;
                        wake_next     = 1'b1;
                    end
                    else
                    begin
                        refuse_next = 1'b1;
                    end
                end
                else if (!cpu_wait_stop)
                begin
                    state_next = ST_RUN;
                end
            end
            ST_HALT:
            begin
                if (cmd_go)
                begin
                    state_next    = ST_RUN;
                    ws_entry_next = 1'b0;
                end
            end
            default:
            begin
                state_next    = ST_RUN;
                ws_entry_next = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // register and sequencer flops
    // ****************************************************************
    // a target reset picks its image from whether the halt is active
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg      <= ST_RUN;
            permit_reg     <= 1'b0;
            bp_enable_reg  <= 1'b0;
            force_tag_reg  <= 1'b0;
            clk_select_reg <= 1'b0;
            ws_entry_reg   <= 1'b0;
            force_pend_reg <= 1'b0;
        end
        else if (target_reset)
        begin
            if (halted)
            begin
                state_reg      <= ST_HALT;
                permit_reg     <= scr_halt_bit(`PERMIT_BIT);
                clk_select_reg <= scr_halt_bit(`CLK_SELECT_BIT);
            end
            else
            begin
                state_reg      <= ST_RUN;
                permit_reg     <= 1'b0;
                clk_select_reg <= 1'b0;
            end
            bp_enable_reg  <= 1'b0;
            force_tag_reg  <= 1'b0;
            ws_entry_reg   <= 1'b0;
            force_pend_reg <= 1'b0;
        end
        else
        begin
            state_reg      <= state_next;
            ws_entry_reg   <= ws_entry_next;
            force_pend_reg <= force_pend_next;
            // only the writable fields move; status bits ignore writes
            if (cmd_write_control)
            begin
                permit_reg     <= permit_reg | cmd_wdata[`PERMIT_BIT];
                bp_enable_reg  <= cmd_wdata[`BP_ENABLE_BIT];
                force_tag_reg  <= cmd_wdata[`FORCE_TAG_BIT];
                clk_select_reg <= cmd_wdata[`CLK_SELECT_BIT];
            end
        end
    end

    // ****************************************************************
    // failure flags
    // ****************************************************************
    // cleared when the next memory command starts; a failure in that
    // same cycle still wins so it is never lost
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ws_fail_reg   <= 1'b0;
            slow_fail_reg <= 1'b0;
        end
        else if (target_reset)
        begin
            ws_fail_reg   <= 1'b0;
            slow_fail_reg <= 1'b0;
        end
        else
        begin
            if (mem_fail_wait_stop)
            begin
                ws_fail_reg <= 1'b1;
            end
            else if (mem_cmd_start)
            begin
                ws_fail_reg <= 1'b0;
            end
            if (mem_fail_slow)
            begin
                slow_fail_reg <= 1'b1;
            end
            else if (mem_cmd_start)
            begin
                slow_fail_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // command answers and cpu pulses
    // ****************************************************************
    // read data is a snapshot taken on the read command
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            status_rdata       <= `SCR_RESET;
            status_rvalid      <= 1'b0;
            swi_req            <= 1'b0;
            cpu_wake_req       <= 1'b0;
            background_refused <= 1'b0;
        end
        else
        begin
            status_rvalid      <= cmd_read_status;
            swi_req            <= swi_next & ~target_reset;
            cpu_wake_req       <= wake_next & ~target_reset;
            background_refused <= refuse_next & ~target_reset;
            if (cmd_read_status)
            begin
                status_rdata <= scr_value;
            end
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    // bit of the image loaded by a reset taken while halted
    function scr_halt_bit;
        input integer pos;
        reg [7:0] image;
        begin
            image        = `SCR_HALT_RESET;
            scr_halt_bit = image[pos];
        end
    endfunction

endmodule // debug_status_control

`default_nettype wire

// ### logic/debug_status_control_defines.vh
`ifndef DEBUG_STATUS_CONTROL_DEFINES_VH
`define DEBUG_STATUS_CONTROL_DEFINES_VH

// ****************************************************************
// register map
// ****************************************************************
`define SCR_OFFSET       8'h00
`define SCR_RESET        8'h00
`define SCR_HALT_RESET   8'hc8
`define SCR_WRITE_MASK   8'hb8

// ****************************************************************
// field positions
// ****************************************************************
`define PERMIT_BIT       7
`define ACTIVE_BIT       6
`define BP_ENABLE_BIT    5
`define FORCE_TAG_BIT    4
`define CLK_SELECT_BIT   3
`define WAIT_STOP_BIT    2
`define WS_FAIL_BIT      1
`define SLOW_FAIL_BIT    0

// ****************************************************************
// widths
// ****************************************************************
`define CPU_ADDR_WIDTH   16

`endif

// ### logic/breakpoint_compare.v
`default_nettype none

// ****************************************************************
// breakpoint address comparator
// ****************************************************************
module breakpoint_compare
#(
    parameter ADDR_WIDTH = 16
)
(
    // enable and qualifier
    input  wire                  compare_enable,
    input  wire                  bus_valid,
    // addresses
    input  wire [ADDR_WIDTH-1:0] bus_addr,
    input  wire [ADDR_WIDTH-1:0] match_addr,
    // result
    output wire                  addr_hit
);

    // the enable gates everything, so a stale match address is harmless
    assign addr_hit = compare_enable & bus_valid & (bus_addr == match_addr);

endmodule // breakpoint_compare

`default_nettype wire

// ### bench/debug_status_control_props.sv
`default_nettype none

// ****************************************************************
// port checker for the debug status register
// ****************************************************************
module debug_status_control_props
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rstn,
    // command side
    input wire logic       target_reset,
    input wire logic       cmd_read_status,
    input wire logic       cmd_write_control,
    input wire logic [7:0] cmd_wdata,
    input wire logic       cmd_background,
    input wire logic       cmd_go,
    input wire logic       mem_cmd_start,
    input wire logic       mem_fail_slow,
    input wire logic [7:0] status_rdata,
    input wire logic       status_rvalid,
    input wire logic       background_refused,
    input wire logic       active_cmds_allowed,
    // cpu side
    input wire logic       opcode_fetch,
    input wire logic       cpu_wait_stop,
    input wire logic       tag_opcode,
    input wire logic       halt_active_flag,
    input wire logic       link_clock_select
);
    timeunit 1ns;
    timeprecision 1ns;

    // one domain, so one clock and one disable for all
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    property p_rvalid;
        cmd_read_status |=> status_rvalid;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer missing");

    property p_active_bit;
        status_rvalid |-> status_rdata[6] == $past(halt_active_flag);
    endproperty
    a_active_bit: assert property (p_active_bit) else $error("active bit wrong");

    property p_refused;
        background_refused |-> $past(cmd_background) && !halt_active_flag;
    endproperty
    a_refused: assert property (p_refused) else $error("refusal wrong");

    property p_go;
        halt_active_flag && cmd_go && !cmd_background && !target_reset |=> !halt_active_flag;
    endproperty
    a_go: assert property (p_go) else $error("resume ignored");

    property p_allowed;
        active_cmds_allowed == (halt_active_flag && !cpu_wait_stop);
    endproperty
    a_allowed: assert property (p_allowed) else $error("allowed flag wrong");

    property p_tag;
        tag_opcode |-> opcode_fetch;
    endproperty
    a_tag: assert property (p_tag) else $error("tag outside fetch");

    property p_trst_halt;
        target_reset && halt_active_flag |=> halt_active_flag && link_clock_select;
    endproperty
    a_trst_halt: assert property (p_trst_halt) else $error("halted reset image");

    property p_trst_run;
        target_reset && !halt_active_flag |=> !halt_active_flag && !link_clock_select;
    endproperty
    a_trst_run: assert property (p_trst_run) else $error("run reset image");

    property p_slow_fail;
        (mem_fail_slow && !target_reset) ##1 (!target_reset && !mem_cmd_start)
            ##1 cmd_read_status |=> status_rdata[0];
    endproperty
    a_slow_fail: assert property (p_slow_fail) else $error("slow flag lost");

    property p_write;
        (cmd_write_control && !target_reset) ##1 (!cmd_write_control && !target_reset)
            ##1 (cmd_read_status && !cmd_write_control)
            |=> status_rdata[5:3] == $past(cmd_wdata[5:3], 3);
    endproperty
    a_write: assert property (p_write) else $error("control write lost");
endmodule // debug_status_control_props

`default_nettype wire

// ### bench/debug_host_model.sv
`default_nettype none

// ****************************************************************
// debug host issuing serial commands
// ****************************************************************
module debug_host_model
(
    // clock
    input wire logic       clk_sys,
    // commands
    output var logic       cmd_read_status,
    output var logic       cmd_write_control,
    output var logic [7:0] cmd_wdata,
    output var logic       cmd_background,
    output var logic       cmd_go,
    // answers
    input wire logic [7:0] status_rdata,
    input wire logic       status_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle host drives nothing active
    initial
    begin
        {cmd_read_status, cmd_write_control, cmd_background, cmd_go} = 4'h0;
        cmd_wdata = 8'h00;
    end

    // strobe held over exactly one sampling edge
    task automatic write_ctrl(input logic [7:0] v);
        @(posedge clk_sys);
        cmd_write_control <= 1'b1;
        cmd_wdata         <= v;
        @(posedge clk_sys);
        cmd_write_control <= 1'b0;
        cmd_wdata         <= ~v; // stale data must not look valid
    endtask

    // answer is taken after the edge that launched it
    task automatic read_status(output logic [7:0] v, output logic ok);
        @(posedge clk_sys);
        cmd_read_status <= 1'b1;
        @(posedge clk_sys);
        cmd_read_status <= 1'b0;
        #1;
        v  = status_rdata;
        ok = status_rvalid;
    endtask

    // background when bg is 1, resume otherwise
    task automatic pulse_cmd(input logic bg);
        @(posedge clk_sys);
        if (bg)
            cmd_background <= 1'b1;
        else
            cmd_go <= 1'b1;
        @(posedge clk_sys);
        cmd_background <= 1'b0;
        cmd_go         <= 1'b0;
        #1;
    endtask
endmodule // debug_host_model

`default_nettype wire

// ### bench/test_debug_status_control.sv
`default_nettype none

// ****************************************************************
// testbench for the debug status register
// ****************************************************************
module test_debug_status_control;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [15:0] BP = 16'h1234;
    localparam logic [5:0] E_BND = 6'h01, E_QEND = 6'h02, E_SLOW = 6'h04;
    localparam logic [5:0] E_WSF = 6'h08, E_START = 6'h10, E_TRST = 6'h20;

    logic        clk_sys, rstn;
    logic [5:0]  ev;
    logic [15:0] cpu_addr, bp_addr;
    logic        cpu_addr_valid, opcode_fetch, cpu_wait_stop;
    logic        cmd_read_status, cmd_write_control, cmd_background, cmd_go;
    logic [7:0]  cmd_wdata, status_rdata;
    logic        status_rvalid, background_refused, active_cmds_allowed, tag_opcode;
    logic        halt_active_flag, cpu_wake_req, swi_req, link_clock_select;
    int          n_mismatch = 0, checks = 0, cyc = 0;

    debug_status_control dut (
        .clk_sys(clk_sys), .rstn(rstn), .target_reset(ev[5]),
        .cmd_read_status(cmd_read_status), .cmd_write_control(cmd_write_control),
        .cmd_wdata(cmd_wdata), .cmd_background(cmd_background), .cmd_go(cmd_go),
        .mem_cmd_start(ev[4]), .mem_fail_wait_stop(ev[3]), .mem_fail_slow(ev[2]),
        .status_rdata(status_rdata), .status_rvalid(status_rvalid),
        .background_refused(background_refused), .active_cmds_allowed(active_cmds_allowed),
        .cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid), .opcode_fetch(opcode_fetch),
        .instr_boundary(ev[0]), .tagged_at_queue_end(ev[1]), .cpu_wait_stop(cpu_wait_stop),
        .breakpoint_match_address(bp_addr), .tag_opcode(tag_opcode),
        .halt_active_flag(halt_active_flag), .cpu_wake_req(cpu_wake_req), .swi_req(swi_req),
        .link_clock_select(link_clock_select)
    );

    debug_host_model host (
        .clk_sys(clk_sys), .cmd_read_status(cmd_read_status),
        .cmd_write_control(cmd_write_control), .cmd_wdata(cmd_wdata),
        .cmd_background(cmd_background), .cmd_go(cmd_go),
        .status_rdata(status_rdata), .status_rvalid(status_rvalid)
    );

    // free running clock
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rd(input logic [7:0] exp);
        logic [7:0] v;
        logic       ok;
        host.read_status(v, ok);
        check("rvalid", {7'h00, ok}, 8'h01);
        check("status", v, exp);
    endtask

    // one-cycle event pulse, outputs settled on return
    task automatic pulse(input logic [5:0] p);
        @(posedge clk_sys);
        ev <= p;
        @(posedge clk_sys);
        ev <= 6'h00;
        #1;
    endtask

    // address hit for one cycle, then an instruction boundary
    task automatic hit_then_boundary();
        @(posedge clk_sys);
        cpu_addr       <= BP;
        cpu_addr_valid <= 1'b1;
        @(posedge clk_sys);
        cpu_addr_valid <= 1'b0;
        cpu_addr       <= 16'h0000;
        pulse(E_BND);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // hang guard, run needs about 110 cycles
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    // main sequence
    initial
    begin
        rstn           <= 1'b0;
        ev             <= 6'h00;
        cpu_addr       <= 16'h0000;
        bp_addr        <= BP;
        cpu_addr_valid <= 1'b0;
        opcode_fetch   <= 1'b0;
        cpu_wait_stop  <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(8'h00);
        host.pulse_cmd(1'b1);
        check("refused", {7'h00, background_refused}, 8'h01);
        check("halt", {7'h00, halt_active_flag}, 8'h00);
        host.write_ctrl(8'h47);
        rd(8'h00);
        host.write_ctrl(8'h38);
        rd(8'h38);
        check("clksel", {7'h00, link_clock_select}, 8'h01);
        host.write_ctrl(8'h80);
        host.write_ctrl(8'h00);
        rd(8'h80);
        host.pulse_cmd(1'b1);
        rd(8'hc0);
        check("allowed", {7'h00, active_cmds_allowed}, 8'h01);
        pulse(E_TRST);
        rd(8'hc8);
        host.pulse_cmd(1'b0);
        rd(8'h88);
        pulse(E_SLOW);
        rd(8'h89);
        pulse(E_WSF);
        rd(8'h8b);
        pulse(E_START);
        rd(8'h88);
        host.write_ctrl(8'hb8);
        hit_then_boundary();
        check("force halt", {7'h00, halt_active_flag}, 8'h01);
        rd(8'hf8);
        host.pulse_cmd(1'b0);
        host.write_ctrl(8'h98);
        hit_then_boundary();
        check("disabled", {7'h00, halt_active_flag}, 8'h00);
        host.write_ctrl(8'ha8);
        @(posedge clk_sys);
        cpu_addr       <= BP;
        cpu_addr_valid <= 1'b1;
        opcode_fetch   <= 1'b1;
        @(posedge clk_sys);
        #1;
        check("tag", {7'h00, tag_opcode}, 8'h01);
        @(posedge clk_sys);
        cpu_addr_valid <= 1'b0;
        opcode_fetch   <= 1'b0;
        pulse(E_QEND);
        check("tag halt", {7'h00, halt_active_flag}, 8'h01);
        host.pulse_cmd(1'b0);
        @(posedge clk_sys);
        cpu_wait_stop <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd(8'hac);
        host.pulse_cmd(1'b1);
        check("wake", {7'h00, cpu_wake_req}, 8'h01);
        @(posedge clk_sys);
        cpu_wait_stop <= 1'b0;
        rd(8'hec);
        host.pulse_cmd(1'b0);
        rd(8'ha8);
        @(posedge clk_sys);
        rstn <= 1'b0;
        @(posedge clk_sys);
        rstn <= 1'b1;
        rd(8'h00);
        host.write_ctrl(8'h30);
        hit_then_boundary();
        check("swi", {7'h00, swi_req}, 8'h01);
        check("no halt", {7'h00, halt_active_flag}, 8'h00);
        // match address moved away from the bus address, so no request
        @(posedge clk_sys);
        bp_addr <= 16'h4321;
        hit_then_boundary();
        check("swi miss", {7'h00, swi_req}, 8'h00);
        // target reset while running clears everything, link clock too
        host.write_ctrl(8'h38);
        pulse(E_TRST);
        rd(8'h00);
        final_report();
    end
endmodule // test_debug_status_control

bind debug_status_control debug_status_control_props u_props (
    .clk_sys(clk_sys), .rstn(rstn), .target_reset(target_reset),
    .cmd_read_status(cmd_read_status), .cmd_write_control(cmd_write_control),
    .cmd_wdata(cmd_wdata), .cmd_background(cmd_background), .cmd_go(cmd_go),
    .mem_cmd_start(mem_cmd_start), .mem_fail_slow(mem_fail_slow),
    .status_rdata(status_rdata),
    .status_rvalid(status_rvalid), .background_refused(background_refused),
    .active_cmds_allowed(active_cmds_allowed), .opcode_fetch(opcode_fetch),
    .cpu_wait_stop(cpu_wait_stop), .tag_opcode(tag_opcode),
    .halt_active_flag(halt_active_flag), .link_clock_select(link_clock_select)
);

`default_nettype wire
